// >>> pae_alarm_evaluator.sv
// Contract
// [R01] Type 9: alarm while process value below value
// [R02] Types 10, 11: absolute alarms with standby
// [R03] Type 14: alarm while set point above value
// [R04] Type 15: alarm while set point below value
// [R05] Type 16: alarm while output above value
// [R06] Type 17: alarm while output below value
// [R07] Heat/cool: upper uses heating, lower cooling
// [R08] Types 1, 4, 5 use separate limits
// [R09] Type 5 off when hysteresis bands overlap
// [R10] Stopped reset/standby: deviation uses segment 0; in reset only when PAE_CTRL_PROG_SP_MODE is set
// [R11] Rate-rise soak segment 0: reference is PV
// [R12] Four alarms, each with upper/lower limits
// [R13] Type 8: alarm while process value above value
// [R14] Standby: leave region, then re-enter to alarm
// [R15] Standby cancelled once alarmed; rearm by reset
// [R16] Evaluate per sample, hysteresis before release
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "pae_params.svh"

module pae_alarm_evaluator (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sample_tick,
    input wire pae_pkg::pae_val_t process_value,
    input wire pae_pkg::pae_val_t set_point,
    input wire pae_pkg::pae_val_t seg0_set_point,
    input wire pae_pkg::pae_val_t manipulated_value,
    input wire pae_pkg::pae_val_t cool_manipulated_value,
    input wire logic prog_reset,
    input wire logic prog_standby,
    output logic [3:0] alarm_out,
    output logic irq
);
    import pae_pkg::*;

    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [31:0] rdata_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;

    logic [31:0] ctrl_ff;
    logic [31:0] cfg_ff [0:3];
    logic [31:0] val_ff [0:3];
    logic [31:0] lim_ff [0:3];
    logic [3:0] ien_ff;
    logic [3:0] ist_ff;
    logic irq_ff;

    logic [3:0] hi_ff;
    logic [3:0] lo_ff;
    logic [3:0] alarm_ff;
    logic [3:0] wait_ff;
    logic [3:0] nxt_hi;
    logic [3:0] nxt_lo;
    logic [3:0] nxt_alarm;
    logic [3:0] nxt_wait;
    logic [3:0] raw;
    logic [3:0] rearm;

    // Write path: both address and data held, no response pending
    wire aw_take = s_axi_awvalid & awready_ff;
    wire w_take = s_axi_wvalid & wready_ff;
    wire wr_fire = ~awready_ff & ~wready_ff & ~bvalid_ff;
    wire [7:0] wa = awaddr_ff;
    wire wa_alm = (wa[7:6] == `PAE_OFF_ALARM_BASE) & (wa[3:2] != 2'h3) & (wa[1:0] == 2'h0);
    wire wa_ok = wa_alm | (wa == `PAE_OFF_CTRL) | (wa == `PAE_OFF_STATUS)
        | (wa == `PAE_OFF_INT_STATUS) | (wa == `PAE_OFF_INT_CLEAR)
        | (wa == `PAE_OFF_INT_ENABLE);
    wire w_ctrl = wr_fire & (wa == `PAE_OFF_CTRL);
    wire w_iclr = wr_fire & (wa == `PAE_OFF_INT_CLEAR);
    wire w_ien = wr_fire & (wa == `PAE_OFF_INT_ENABLE);
    wire w_alm = wr_fire & wa_alm;
    wire [1:0] w_idx = wa[5:4];
    wire [1:0] w_sub = wa[3:2];
    wire [31:0] wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
    wire [31:0] ctrl_new = ((ctrl_ff & ~wmask) | (wdata_ff & wmask)) & `PAE_CTRL_MASK;
    wire [31:0] cfg_new = ((cfg_ff[w_idx] & ~wmask) | (wdata_ff & wmask)) & `PAE_CFG_MASK;
    wire [31:0] val_new = ((val_ff[w_idx] & ~wmask) | (wdata_ff & wmask)) & `PAE_VALUE_MASK;
    wire [31:0] lim_new = (lim_ff[w_idx] & ~wmask) | (wdata_ff & wmask);
    wire [3:0] int_clr = w_iclr ? (wdata_ff[3:0] & {4{wstrb_ff[0]}}) : 4'h0;
    wire [3:0] ien_new = wstrb_ff[0] ? wdata_ff[3:0] : ien_ff;

    // Read path: one word captured at the address handshake
    wire ar_take = s_axi_arvalid & arready_ff;
    wire [7:0] ra = s_axi_araddr;
    wire ra_alm = (ra[7:6] == `PAE_OFF_ALARM_BASE) & (ra[3:2] != 2'h3) & (ra[1:0] == 2'h0);
    wire ra_ok = ra_alm | (ra == `PAE_OFF_CTRL) | (ra == `PAE_OFF_STATUS)
        | (ra == `PAE_OFF_INT_STATUS) | (ra == `PAE_OFF_INT_CLEAR)
        | (ra == `PAE_OFF_INT_ENABLE);
    wire [31:0] rd_alm = (ra[3:2] == `PAE_SUB_CFG) ? cfg_ff[ra[5:4]]
        : (ra[3:2] == `PAE_SUB_VALUE) ? val_ff[ra[5:4]] : lim_ff[ra[5:4]];
    wire [31:0] rd_word = ra_alm ? rd_alm
        : (ra == `PAE_OFF_CTRL) ? ctrl_ff
        : (ra == `PAE_OFF_STATUS) ? {24'h000000, wait_ff, alarm_ff}
        : (ra == `PAE_OFF_INT_STATUS) ? {28'h0000000, ist_ff}
        : (ra == `PAE_OFF_INT_ENABLE) ? {28'h0000000, ien_ff} : 32'h00000000;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= `PAE_RESP_OKAY;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end else begin
            if (aw_take) begin
                awready_ff <= 1'b0;
                awaddr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                wready_ff <= 1'b0;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= wa_ok ? `PAE_RESP_OKAY : `PAE_RESP_SLVERR;
            end else if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rresp_ff <= `PAE_RESP_OKAY;
            rdata_ff <= 32'h00000000;
        end else if (ar_take) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= ra_ok ? `PAE_RESP_OKAY : `PAE_RESP_SLVERR;
        end else if (rvalid_ff && s_axi_rready) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_ff <= `PAE_RST_CTRL;
            ien_ff <= `PAE_RST_INT_ENABLE;
        end else begin
            if (w_ctrl) begin
                ctrl_ff <= ctrl_new;
            end
            if (w_ien) begin
                ien_ff <= ien_new;
            end
        end
    end

    // Four independent alarm configurations
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (!rstn) begin
                cfg_ff[i] <= `PAE_RST_CFG;
                val_ff[i] <= `PAE_RST_VALUE;
                lim_ff[i] <= `PAE_RST_LIMITS; // R12
            end else if (w_alm && (w_idx == 2'(i))) begin
                if (w_sub == `PAE_SUB_CFG) begin
                    cfg_ff[i] <= cfg_new;
                end
                if (w_sub == `PAE_SUB_VALUE) begin
                    val_ff[i] <= val_new;
                end
                if (w_sub == `PAE_SUB_LIMITS) begin
                    lim_ff[i] <= lim_new; // R12
                end
            end
        end
    end

    // Reference set point for deviation types during program reset or standby
    wire heat_cool = ctrl_ff[`PAE_CTRL_HEAT_COOL];
    wire reset_stop = ctrl_ff[`PAE_CTRL_RESET_STOP];
    wire held = prog_reset | prog_standby;
    wire use_seg0 = reset_stop & ((prog_reset & ctrl_ff[`PAE_CTRL_PROG_SP_MODE]) | prog_standby); // R10
    wire use_pv = reset_stop & held & ctrl_ff[`PAE_CTRL_RATE_RISE] & ctrl_ff[`PAE_CTRL_SEG0_SOAK]; // R11
    wire pae_wide_t pv_w = pae_ext(process_value);
    wire pae_wide_t ref_w = use_pv ? pv_w
        : use_seg0 ? pae_ext(seg0_set_point) : pae_ext(set_point);
    wire pae_wide_t dev_w = pv_w - ref_w;
    wire pae_wide_t sp_w = pae_ext(set_point);
    wire pae_wide_t heat_w = pae_ext(manipulated_value);
    wire pae_wide_t cool_w = heat_cool ? pae_ext(cool_manipulated_value) : heat_w; // R07

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_alarm
            wire [4:0] ty = cfg_ff[g][4:0];
            wire pae_wide_t hy = {2'b00, cfg_ff[g][31:16]};
            wire pae_wide_t xv = pae_ext(val_ff[g][15:0]);
            wire pae_wide_t uh = pae_ext(lim_ff[g][31:16]);
            wire pae_wide_t ul = pae_ext(lim_ff[g][15:0]);
            wire is_dev = (ty >= PAE_T_DEV_UL) & (ty <= PAE_T_DEV_L_STBY);
            wire is_pair = (ty == PAE_T_DEV_UL) | (ty == PAE_T_DEV_RANGE)
                | (ty == PAE_T_DEV_UL_STBY);
            wire is_stby = (ty == PAE_T_DEV_UL_STBY) | (ty == PAE_T_DEV_U_STBY)
                | (ty == PAE_T_DEV_L_STBY) | (ty == PAE_T_ABS_U_STBY)
                | (ty == PAE_T_ABS_L_STBY); // R02
            wire hi_use = is_pair | (ty == PAE_T_DEV_U) | (ty == PAE_T_DEV_U_STBY)
                | (ty == PAE_T_ABS_U) | (ty == PAE_T_ABS_U_STBY)
                | (ty == PAE_T_SP_U) | (ty == PAE_T_MV_U); // R13 R03 R05
            wire lo_use = is_pair | (ty == PAE_T_DEV_L) | (ty == PAE_T_DEV_L_STBY)
                | (ty == PAE_T_ABS_L) | (ty == PAE_T_ABS_L_STBY)
                | (ty == PAE_T_SP_L) | (ty == PAE_T_MV_L); // R01 R04 R06
            // Monitored value: upper output alarm sees heating, lower sees cooling in heat/cool mode and heating otherwise
            wire pae_wide_t mon = is_dev ? dev_w
                : ((ty == PAE_T_SP_U) | (ty == PAE_T_SP_L)) ? sp_w
                : (ty == PAE_T_MV_U) ? heat_w
                : (ty == PAE_T_MV_L) ? cool_w : pv_w; // R07
            wire pae_wide_t hlim = is_pair ? uh : xv; // R08
            wire pae_wide_t llim = is_pair ? -ul : (is_dev ? -xv : xv); // R08
            wire pae_wide_t hrel = hlim - hy;
            wire pae_wide_t lrel = llim + hy;
            wire overlap = (hrel <= lrel);
            // Active bands release only past the hysteresis band
            assign nxt_hi[g] = hi_use & (hi_ff[g] ? (mon > hrel) : (mon > hlim)); // R16
            assign nxt_lo[g] = lo_use & (lo_ff[g] ? (mon < lrel) : (mon < llim)); // R16
            assign raw[g] = (ty == PAE_T_DEV_RANGE) ? ~(nxt_hi[g] | nxt_lo[g])
                : (nxt_hi[g] | nxt_lo[g]);
            wire block = (ty == PAE_T_DEV_UL_STBY) & overlap; // R09
            assign nxt_alarm[g] = raw[g] & ~block & ~(is_stby & wait_ff[g]); // R14
            assign rearm[g] = w_alm & (w_idx == 2'(g)) & (w_sub == `PAE_SUB_CFG);
            // Standby waits until the region is left once; only a rearm or reset restores it
            assign nxt_wait[g] = rearm[g] ? 1'b1
                : (sample_tick & ~raw[g]) ? 1'b0 : wait_ff[g]; // R14 R15
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rstn) begin
            hi_ff <= 4'h0;
            lo_ff <= 4'h0;
            alarm_ff <= 4'h0;
        end else if (sample_tick) begin
            hi_ff <= nxt_hi; // R16
            lo_ff <= nxt_lo;
            alarm_ff <= nxt_alarm; // R16
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            wait_ff <= 4'hF;
        end else begin
            wait_ff <= nxt_wait; // R15
        end
    end

    // Sticky alarm-rise events; a new event wins over a clear
    wire [3:0] rise = sample_tick ? (nxt_alarm & ~alarm_ff) : 4'h0;
    wire [3:0] nxt_ist = (ist_ff & ~int_clr) | rise;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ist_ff <= 4'h0;
            irq_ff <= 1'b0;
        end else begin
            ist_ff <= nxt_ist;
            irq_ff <= |(ist_ff & ien_ff);
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = rdata_ff;
    assign alarm_out = alarm_ff;
    assign irq = irq_ff;

endmodule : pae_alarm_evaluator
`default_nettype wire

// >>> pae_alarm_evaluator_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module pae_alarm_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic sample_tick,
    input wire pae_pkg::pae_val_t process_value,
    input wire pae_pkg::pae_val_t set_point,
    input wire pae_pkg::pae_val_t manipulated_value,
    input wire pae_pkg::pae_val_t cool_manipulated_value,
    input wire logic [3:0] alarm_out
);
    import pae_pkg::*;
    logic wr, tk, hc_ff, new_ff;
    logic [4:0] typ_ff;
    logic [15:0] hys_ff;
    pae_val_t x_ff;
    // Shadow of alarm 0 setup, snooped from bus writes
    assign wr = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
    assign tk = sample_tick & (hys_ff == 16'h0);
    always_ff @(posedge clk) begin
        if (!rstn) begin
            typ_ff <= 5'h02;
            hys_ff <= 16'h0;
            x_ff <= 16'h0;
            hc_ff <= 1'h0;
            new_ff <= 1'h1;
        end else if (wr) begin
            if (s_axi_awaddr == 8'h40) {hys_ff, typ_ff, new_ff} <= {s_axi_wdata[31:16], s_axi_wdata[4:0], 1'h1};
            if (s_axi_awaddr == 8'h44) x_ff <= s_axi_wdata[15:0];
            if (s_axi_awaddr == 8'h00) hc_ff <= s_axi_wdata[0];
        end else if (sample_tick) begin
            new_ff <= 1'h0;
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstn);
    a_hold_idle: assert property (!sample_tick |=> $stable(alarm_out))
        else $error("alarm changed without a sample tick");
    a_off_type: assert property (sample_tick && typ_ff == PAE_T_OFF |=> !alarm_out[0])
        else $error("disabled alarm asserted");
    a_pv_upper: assert property (tk && typ_ff == PAE_T_ABS_U |=> alarm_out[0] == ($past(process_value) > $past(x_ff)))
        else $error("process upper alarm wrong");
    a_pv_lower: assert property (tk && typ_ff == PAE_T_ABS_L |=> alarm_out[0] == ($past(process_value) < $past(x_ff)))
        else $error("process lower alarm wrong");
    a_sp_upper: assert property (tk && typ_ff == PAE_T_SP_U |=> alarm_out[0] == ($past(set_point) > $past(x_ff)))
        else $error("set point upper alarm wrong");
    a_sp_lower: assert property (tk && typ_ff == PAE_T_SP_L |=> alarm_out[0] == ($past(set_point) < $past(x_ff)))
        else $error("set point lower alarm wrong");
    a_mv_upper: assert property (tk && typ_ff == PAE_T_MV_U |=> alarm_out[0] == ($past(manipulated_value) > $past(x_ff)))
        else $error("output upper alarm wrong");
    a_mv_lower: assert property (tk && typ_ff == PAE_T_MV_L |=> alarm_out[0] == (($past(hc_ff) ? $past(cool_manipulated_value) : $past(manipulated_value)) < $past(x_ff)))
        else $error("output lower alarm wrong");
    a_standby_first: assert property (sample_tick && new_ff && (typ_ff == PAE_T_ABS_U_STBY || typ_ff == PAE_T_ABS_L_STBY) |=> !alarm_out[0])
        else $error("standby alarm asserted on first sample");
endmodule : pae_alarm_chk
bind pae_alarm_evaluator pae_alarm_chk pae_alarm_chk_inst (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .sample_tick, .process_value, .set_point, .manipulated_value, .cool_manipulated_value, .alarm_out);
`default_nettype wire

// >>> pae_meas_model.sv
`timescale 1ns/10ps
`default_nettype none
module pae_meas_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic req,
    input wire pae_pkg::pae_val_t pv_in,
    output var pae_pkg::pae_val_t process_value,
    output var logic sample_tick
);
    import pae_pkg::*;
    // A new measurement lands together with its one-cycle sampling pulse
    always_ff @(posedge clk) begin
        if (!rstn) begin
            process_value <= 16'h0000;
            sample_tick <= 1'h0;
        end else begin
            sample_tick <= req;
            if (req) process_value <= pv_in;
        end
    end
endmodule : pae_meas_model
`default_nettype wire

// >>> pae_params.svh
`ifndef PAE_PARAMS_SVH
`define PAE_PARAMS_SVH

// Register byte offsets, then alarm field codes for address bits 7:6 and 3:2
`define PAE_OFF_CTRL 8'h00
`define PAE_OFF_STATUS 8'h04
`define PAE_OFF_INT_STATUS 8'h08
`define PAE_OFF_INT_CLEAR 8'h0C
`define PAE_OFF_INT_ENABLE 8'h10
`define PAE_OFF_ALARM_BASE 2'h1
`define PAE_SUB_CFG 2'h0
`define PAE_SUB_VALUE 2'h1
`define PAE_SUB_LIMITS 2'h2

// Control register bit positions
`define PAE_CTRL_HEAT_COOL 0
`define PAE_CTRL_RESET_STOP 1
`define PAE_CTRL_PROG_SP_MODE 2
`define PAE_CTRL_RATE_RISE 3
`define PAE_CTRL_SEG0_SOAK 4
`define PAE_CTRL_MASK 32'h0000001F

// Per-alarm configuration word: type in 4:0, hysteresis in 31:16
`define PAE_CFG_MASK 32'hFFFF001F
`define PAE_VALUE_MASK 32'h0000FFFF

// Reset values
`define PAE_RST_CTRL 32'h00000000
`define PAE_RST_CFG 32'h00000002
`define PAE_RST_VALUE 32'h00000000
`define PAE_RST_LIMITS 32'h00000000
`define PAE_RST_INT_ENABLE 4'h0

// AXI responses
`define PAE_RESP_OKAY 2'h0
`define PAE_RESP_SLVERR 2'h2

`endif

// >>> pae_pkg.sv
`default_nettype none
package pae_pkg;

    typedef logic signed [15:0] pae_val_t;
    typedef logic signed [17:0] pae_wide_t;

    typedef enum logic [4:0] {
        PAE_T_OFF = 5'h00,
        PAE_T_DEV_UL = 5'h01,
        PAE_T_DEV_U = 5'h02,
        PAE_T_DEV_L = 5'h03,
        PAE_T_DEV_RANGE = 5'h04,
        PAE_T_DEV_UL_STBY = 5'h05,
        PAE_T_DEV_U_STBY = 5'h06,
        PAE_T_DEV_L_STBY = 5'h07,
        PAE_T_ABS_U = 5'h08,
        PAE_T_ABS_L = 5'h09,
        PAE_T_ABS_U_STBY = 5'h0A,
        PAE_T_ABS_L_STBY = 5'h0B,
        PAE_T_LOOP_BREAK = 5'h0C,
        PAE_T_RATE = 5'h0D,
        PAE_T_SP_U = 5'h0E,
        PAE_T_SP_L = 5'h0F,
        PAE_T_MV_U = 5'h10,
        PAE_T_MV_L = 5'h11
    } pae_type_t;

    function automatic pae_wide_t pae_ext(input logic [15:0] v);
        pae_ext = {{2{v[15]}}, v};
    endfunction : pae_ext

endpackage : pae_pkg
`default_nettype wire

// >>> pae_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "pae_params.svh"
module tb;
    import pae_pkg::*;
    logic clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
    logic sample_tick, prog_reset, prog_standby, req, hc, e;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd, r;
    logic [3:0] s_axi_wstrb, alarm_out;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp, an;
    logic [4:0] t;
    pae_val_t process_value, set_point, seg0_set_point, manipulated_value;
    pae_val_t cool_manipulated_value, pv_in, x, hh, ll, v;
    int error_cnt, cmp_count, dv;
    pae_type_t tl [7] = '{PAE_T_OFF, PAE_T_ABS_U, PAE_T_ABS_L, PAE_T_SP_U, PAE_T_SP_L, PAE_T_MV_U, PAE_T_MV_L};
    pae_val_t hp [9] = '{16'h000B, 16'h0007, 16'h0006, 16'h000A, 16'h000B, 16'h0064, 16'hFF9C, 16'h0000, 16'h0064};
    pae_type_t dl [4] = '{PAE_T_DEV_UL, PAE_T_DEV_RANGE, PAE_T_DEV_U, PAE_T_DEV_L};
    pae_alarm_evaluator pae_alarm_evaluator_inst (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_tick, .process_value, .set_point,
        .seg0_set_point, .manipulated_value, .cool_manipulated_value, .prog_reset, .prog_standby,
        .alarm_out, .irq);
    pae_meas_model pae_meas_model_inst (.clk, .rstn, .req, .pv_in, .process_value, .sample_tick);
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic pae_val_t rv();
        logic [31:0] q;
        q = xs();
        return pae_val_t'({{5{q[10]}}, q[10:0]});
    endfunction : rv
    function automatic logic exp_abs(logic [4:0] ty, logic h, pae_val_t x0);
        case (ty)
            5'h08: return pv_in > x0;
            5'h09: return pv_in < x0;
            5'h0E: return set_point > x0;
            5'h0F: return set_point < x0;
            5'h10: return manipulated_value > x0;
            5'h11: return (h ? cool_manipulated_value : manipulated_value) < x0;
            default: return 1'h0;
        endcase
    endfunction : exp_abs
    function automatic pae_val_t ref_of(logic [4:0] c, logic pr, logic ps);
        if (c[1] && c[3] && c[4] && (pr || ps)) return pv_in;
        if (c[1] && ((pr && c[2]) || ps)) return seg0_set_point;
        return set_point;
    endfunction : ref_of
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        cmp_count++;
        if (got !== ex) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
            if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1 && n < 40);
        s_axi_bready <= 1'h0;
        rsp = s_axi_bresp;
        if (n >= 40) error_cnt++;
        // Let an edge pass so a following call never re-drives bready in this step
        @(posedge clk);
    endtask : axw
    task automatic axr(input logic [7:0] a);
        int n;
        n = 0;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1 && n < 40);
        s_axi_rready <= 1'h0;
        {rd, rsp} = {s_axi_rdata, s_axi_rresp};
        if (n >= 40) error_cnt++;
        @(posedge clk);
    endtask : axr
    task automatic tick(input pae_val_t pv);
        req <= 1'h1;
        pv_in <= pv;
        @(posedge clk);
        req <= 1'h0;
        repeat (3) @(posedge clk);
    endtask : tick
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out
    initial begin
        #(50 * 30000);
        error_cnt++;
        close_out();
    end
    initial begin
        {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {req, prog_reset, prog_standby, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {pv_in, set_point, seg0_set_point, manipulated_value, cool_manipulated_value} = '0;
        s_axi_wstrb = 4'hF;
        seed = 32'h766BAC49;
        repeat (2) @(posedge clk);
        rstn <= 1'h1;
        @(posedge clk);
        axr(`PAE_OFF_CTRL);
        chk("ctrl", `PAE_RST_CTRL, rd);
        axr(8'h40);
        chk("cfg0", `PAE_RST_CFG, rd);
        axr(8'h4C);
        chk("unmapped read", {30'h0, `PAE_RESP_SLVERR}, {30'h0, rsp});
        axw(8'h4C, 32'h1);
        chk("unmapped write", {30'h0, `PAE_RESP_SLVERR}, {30'h0, rsp});
        $display("test registers done");
        for (int i = 0; i < 42; i++) begin
            t = tl[i % 7];
            x = rv();
            r = xs();
            hc = r[0];
            axw(`PAE_OFF_CTRL, {31'h0, hc});
            axw(8'h40, {27'h0, t});
            axw(8'h44, {16'h0, x});
            v = (i % 5 == 0) ? x : rv();
            {set_point, manipulated_value, cool_manipulated_value} <= {rv(), rv(), rv()};
            tick(v);
            chk("absolute", {31'h0, exp_abs(t, hc, x)}, {31'h0, alarm_out[0]});
        end
        $display("test absolute done");
        for (int i = 0; i < 32; i++) begin
            an = i[1:0];
            r = xs();
            if (i < 8) r[5:0] = (i < 4) ? 6'h3A : 6'h26;
            {hh, ll} = {rv(), rv()};
            t = dl[r[8:7]];
            x = rv();
            axw(`PAE_OFF_CTRL, {27'h0, r[4:0]});
            axw({2'h1, an, 4'h0}, {27'h0, t});
            axw({2'h1, an, 4'h4}, {16'h0, x});
            axw({2'h1, an, 4'h8}, {hh, ll});
            {prog_reset, prog_standby} <= r[6:5];
            {set_point, seg0_set_point} <= {rv(), rv()};
            tick(rv());
            dv = int'(pv_in) - int'(ref_of(r[4:0], r[6], r[5]));
            e = (dv > int'(hh)) || (dv < -int'(ll));
            if (t == 5'h04) e = !e;
            if (t == 5'h02) e = dv > int'(x);
            if (t == 5'h03) e = dv < -int'(x);
            chk("deviation", {31'h0, e}, {31'h0, alarm_out[an]});
        end
        $display("test deviation done");
        {prog_reset, prog_standby, set_point} <= '0;
        axw(`PAE_OFF_CTRL, 32'h0);
        axw(`PAE_OFF_INT_CLEAR, 32'hF);
        axw(`PAE_OFF_INT_ENABLE, 32'h1);
        for (int j = 0; j < 2; j++) begin
            t = j ? 5'h0A : 5'h0B;
            axw(8'h40, {27'h0, t});
            axw(8'h44, 32'h0);
            for (int k = 0; k < 6; k++) begin
                if (k == 5) axw(8'h40, {27'h0, t});
                tick((6'h35 >> k & 1) ^ j ? 16'hFFFB : 16'h0005);
                chk("standby", {31'h0, 1'(6'h14 >> k)}, {31'h0, alarm_out[0]});
            end
        end
        axr(`PAE_OFF_INT_STATUS);
        chk("int status", 32'h1, rd & 32'h1);
        chk("irq on", 32'h1, {31'h0, irq});
        axw(`PAE_OFF_INT_ENABLE, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        axw(`PAE_OFF_INT_ENABLE, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        axw(`PAE_OFF_INT_CLEAR, 32'h1);
        axr(`PAE_OFF_INT_STATUS);
        chk("int cleared", 32'h0, rd & 32'h1);
        chk("irq off", 32'h0, {31'h0, irq});
        $display("test standby and interrupt done");
        axw(8'h60, 32'h00050005);
        // Overlapping bands, but the sequence passes through a released state
        axw(8'h68, 32'h00010005);
        axw(8'h70, 32'h00040008);
        axw(8'h74, 32'h0000000A);
        for (int k = 0; k < 9; k++) begin
            tick(hp[k]);
            chk("hysteresis", {30'h0, 1'(9'h133 >> k), 1'h0}, {30'h0, alarm_out[3:2]});
        end
        $display("test hysteresis done");
        close_out();
    end
endmodule : tb
`default_nettype wire
